//--- sbtc_pkg.sv
// sbtc_pkg: command codes, answer codes, field layout and carriers
// assumes framing, header and checksum work is done around the block
package sbtc_pkg;
    localparam logic [7:0] CMD_COMMIT = 8'h47;
    localparam logic [7:0] CMD_ASIC   = 8'h48;
    localparam logic [7:0] CMD_AMB    = 8'h49;
    localparam logic [7:0] CMD_XCVR   = 8'h4A;
    localparam logic [7:0] RSP_FLAG   = 8'h80;
    localparam logic [7:0] RSP_COMMIT = 8'hC7;
    localparam logic [7:0] RSP_ASIC   = 8'hC8;
    localparam logic [7:0] RSP_AMB    = 8'hC9;
    localparam logic [7:0] RSP_XCVR   = 8'hCA;
    localparam logic [4:0] CH_PKG     = 5'h1F;

    // response codes (upper half of the word at bytes 16..19)
    localparam logic [15:0] RC_DONE  = 16'h0000;
    localparam logic [15:0] RC_FAIL  = 16'h0001;
    localparam logic [15:0] RC_UNSUP = 16'h0003;
    // reason codes (lower half), all from the generic range
    localparam logic [15:0] RS_NONE      = 16'h0000;
    localparam logic [15:0] RS_BAD_PARAM = 16'h0002;
    localparam logic [15:0] RS_UNKNOWN   = 16'h0003;
    localparam logic [15:0] RS_INFO_NA   = 16'h0008;
    localparam logic [15:0] RS_GEN_MAX   = 16'h7FFF;

    // ambient word: count in bits 7:0, readings in the bytes above
    localparam int AMB_SLOTS = 3;
    localparam int AMB_W     = 8;
    localparam logic [15:0] XCVR_RSVD = 16'h0000;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] chan_id;
        logic       csum_err;
        logic       id_mismatch;
    } sbtc_cmd_type;

    typedef struct packed {
        logic        valid;
        logic [7:0]  pkt_type;
        logic [7:0]  chan_id;
        logic [15:0] resp_code;
        logic [15:0] reason_code;
        logic [31:0] word20;
        logic [31:0] word24;
    } sbtc_rsp_type;

    // reading minus threshold, one bit wider so it cannot wrap
    function automatic logic signed [16:0] sbtc_margin(
        input logic [15:0] t, input logic [15:0] thr);
        sbtc_margin = $signed({t[15], t}) - $signed({thr[15], thr});
    endfunction
endpackage

//--- sbtc_hot_pick.sv
// sbtc_hot_pick: picks the sensor hottest relative to its threshold
// assumes signed 16-bit readings and thresholds, same clock domain
`timescale 1ns/1ps
`default_nettype none
module sbtc_hot_pick
    import sbtc_pkg::*;
#(
    parameter int N = 2
) (
    input  wire logic [N-1:0][15:0] temp_in,
    input  wire logic [N-1:0][15:0] thr_in,
    output logic      [15:0]        sel_temp,
    output logic      [15:0]        sel_thr
);
    always_comb begin
        int best;
        best = 0;
        for (int i = 1; i < N; i++) begin
            if (sbtc_margin(temp_in[i], thr_in[i]) >
                sbtc_margin(temp_in[best], thr_in[best])) begin
                best = i;
            end
        end
        sel_temp = temp_in[best];
        sel_thr  = thr_in[best];
    end
endmodule // sbtc_hot_pick
`default_nettype wire

//--- sbtc_pin_sync.sv
// sbtc_pin_sync: three-stage synchroniser for slow status pins
// assumes pins are asynchronous levels; output moves when stages agree
`timescale 1ns/1ps
`default_nettype none
module sbtc_pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] lvl_reg;
    logic [W-1:0] lvl_next;

    // a bit changes only once stage two and three agree
    assign lvl_next  = (~(s2_reg ^ s3_reg) & s3_reg) |
                       ((s2_reg ^ s3_reg) & lvl_reg);
    assign level_out = lvl_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end
endmodule // sbtc_pin_sync
`default_nettype wire

//--- sbtc_responder.sv
// sbtc_responder: settings-commit and temperature query responder
// assumes upstream flags checksum and id errors; answer leaves by
// a valid/ready hold, the commit store answers with a done pulse
//
// Functional notes
// - good settings-commit is accepted and answered with type 0xC7.
// - settings-commit answer uses only generic reason codes.
// - word at bytes 16..19 holds response code high, reason code low.
// - ASIC query taken package-addressed (0x1F) or channel-addressed.
// - package ASIC query: internal sensor highest against its threshold.
// - channel ASIC query: that channel's external device, same selection.
// - valid ASIC query always answered with type 0xC8.
// - maximum field is signed 16-bit full-load diode limit in Celsius.
// - current field is signed 16-bit present reading in Celsius.
// - ambient query is package-only, never channel-addressed.
// - without ambient sensors the ambient query is left unimplemented.
// - valid ambient query always answered with type 0xC9.
// - ambient word: count in 7..0, up to three signed bytes above.
// - without temperature module the transceiver query is unimplemented.
// - valid transceiver query always answered with type 0xCA.
// - transceiver values passed exactly as read from the module.
// - each 16-bit transceiver value is one contiguous half-word field.
// - every channel of a shared transceiver answers its own query.
// - absent, silent or unpowered transceiver: information not available.
// - commit persists accepted settings and finalizes dependent ones.
`timescale 1ns/1ps
`default_nettype none
module sbtc_responder
    import sbtc_pkg::*;
#(
    parameter int NUM_CH      = 2,
    parameter int INT_N       = 2,
    parameter int EXT_N       = 2,
    parameter bit HAS_AMBIENT = 1'b1,
    parameter bit HAS_XCVR    = 1'b1
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire sbtc_cmd_type                  cmd_in,
    output logic                               cmd_ready,
    output sbtc_rsp_type                       rsp_out,
    input  wire logic                          rsp_ready,
    input  wire logic [INT_N-1:0][15:0]        int_temp,
    input  wire logic [INT_N-1:0][15:0]        int_thr,
    input  wire logic [NUM_CH*EXT_N-1:0][15:0] ext_temp,
    input  wire logic [NUM_CH*EXT_N-1:0][15:0] ext_thr,
    input  wire logic [7:0]                    amb_count,
    input  wire logic [AMB_SLOTS-1:0][7:0]     amb_temp,
    input  wire logic [NUM_CH-1:0]             xcvr_present_pin,
    input  wire logic [NUM_CH-1:0]             xcvr_power_ok_pin,
    input  wire logic [NUM_CH-1:0]             xcvr_data_ok,
    input  wire logic [NUM_CH-1:0][15:0]       xcvr_temp,
    input  wire logic [NUM_CH-1:0][15:0]       xcvr_alarm_thr,
    input  wire logic [NUM_CH-1:0][15:0]       xcvr_warn_thr,
    output logic                               nv_commit_req,
    output logic                               cfg_finalize,
    input  wire logic                          nv_commit_done,
    input  wire logic                          nv_commit_fail
);
    localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam logic [4:0] NUM_CH_W = 5'(NUM_CH);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COMMIT,
        ST_ANSWER
    } sbtc_state_type;

    sbtc_state_type state_reg;
    sbtc_state_type state_next;
    sbtc_rsp_type   rsp_reg;
    sbtc_rsp_type   rsp_next;
    sbtc_rsp_type   rsp_now;
    logic           ready_reg;
    logic           req_reg;
    logic           fin_reg;
    logic [7:0]     commit_ch_reg;

    // decode of the offered command
    wire       take    = cmd_in.valid && ready_reg;
    wire       drop    = cmd_in.csum_err || cmd_in.id_mismatch;
    wire [4:0] ch      = cmd_in.chan_id[4:0];
    wire       is_pkg  = (ch == CH_PKG);
    wire       ch_ok   = !is_pkg && (ch < NUM_CH_W);
    wire [CHW-1:0] idx = ch[CHW-1:0];
    wire       go_commit = take && !drop &&
                           (cmd_in.code == CMD_COMMIT) && is_pkg;
    wire       commit_end = (state_reg == ST_COMMIT) && nv_commit_done;
    wire       rsp_taken  = (state_reg == ST_ANSWER) && rsp_ready;

    // transceiver status pins come from off-chip
    logic [NUM_CH-1:0] present_s;
    logic [NUM_CH-1:0] power_s;

    sbtc_pin_sync #(.W(2 * NUM_CH)) u_pin_sync (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .pin_in    ({xcvr_present_pin, xcvr_power_ok_pin}),
        .level_out ({present_s, power_s})
    );

    wire xcvr_ready = present_s[idx] && power_s[idx] &&
                      xcvr_data_ok[idx];

    // internal sensors for package-addressed queries
    logic [15:0] int_sel_temp;
    logic [15:0] int_sel_thr;

    sbtc_hot_pick #(.N(INT_N)) u_int_pick (
        .temp_in  (int_temp),
        .thr_in   (int_thr),
        .sel_temp (int_sel_temp),
        .sel_thr  (int_sel_thr)
    );

    // one picker per channel for the attached external devices
    logic [NUM_CH-1:0][15:0] ext_sel_temp;
    logic [NUM_CH-1:0][15:0] ext_sel_thr;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ext
        sbtc_hot_pick #(.N(EXT_N)) u_ext_pick (
            .temp_in  (ext_temp[c*EXT_N +: EXT_N]),
            .thr_in   (ext_thr[c*EXT_N +: EXT_N]),
            .sel_temp (ext_sel_temp[c]),
            .sel_thr  (ext_sel_thr[c])
        );
    end

    // readings beyond the reported count read as zero
    function automatic logic [7:0] amb_slot(input int i,
        input logic [7:0] cnt, input logic [7:0] val);
        amb_slot = (32'(cnt) > i) ? val : 8'h00;
    endfunction

    wire [31:0] asic_pkg_word = {int_sel_thr,
                                 int_sel_temp};
    wire [31:0] asic_ch_word  = {ext_sel_thr[idx],
                                 ext_sel_temp[idx]};
    wire [31:0] amb_word = {amb_slot(2, amb_count, amb_temp[2]),
                            amb_slot(1, amb_count, amb_temp[1]),
                            amb_slot(0, amb_count, amb_temp[0]),
                            amb_count};
    wire [31:0] xcvr_word20 = {xcvr_alarm_thr[idx],
                               xcvr_warn_thr[idx]};
    wire [31:0] xcvr_word24 = {xcvr_temp[idx], XCVR_RSVD};

    // immediate answer for every command except a good commit
    always_comb begin
        rsp_now             = '0;
        rsp_now.valid       = 1'b1;
        rsp_now.pkt_type    = cmd_in.code | RSP_FLAG;
        rsp_now.chan_id     = cmd_in.chan_id;
        rsp_now.resp_code   = RC_DONE;
        rsp_now.reason_code = RS_NONE;
        unique case (cmd_in.code)
            CMD_COMMIT: begin
                // a channel-addressed commit is a bad parameter
                rsp_now.resp_code   = RC_FAIL;
                rsp_now.reason_code = RS_BAD_PARAM;
            end
            CMD_ASIC: begin
                if (is_pkg) begin
                    rsp_now.word20 = asic_pkg_word;
                end else if (ch_ok) begin
                    rsp_now.word20 = asic_ch_word;
                end else begin
                    rsp_now.resp_code   = RC_FAIL;
                    rsp_now.reason_code = RS_BAD_PARAM;
                end
            end
            CMD_AMB: begin
                if (!HAS_AMBIENT) begin
                    rsp_now.resp_code   = RC_UNSUP;
                    rsp_now.reason_code = RS_UNKNOWN;
                end else if (!is_pkg) begin
                    rsp_now.resp_code   = RC_FAIL;
                    rsp_now.reason_code = RS_BAD_PARAM;
                end else begin
                    rsp_now.word20 = amb_word;
                end
            end
            CMD_XCVR: begin
                if (!HAS_XCVR) begin
                    rsp_now.resp_code   = RC_UNSUP;
                    rsp_now.reason_code = RS_UNKNOWN;
                end else if (!ch_ok) begin
                    rsp_now.resp_code   = RC_FAIL;
                    rsp_now.reason_code = RS_BAD_PARAM;
                end else if (!xcvr_ready) begin
                    rsp_now.resp_code   = RC_FAIL;
                    rsp_now.reason_code = RS_INFO_NA;
                end else begin
                    rsp_now.word20 = xcvr_word20;
                    rsp_now.word24 = xcvr_word24;
                end
            end
            default: begin
                rsp_now.resp_code   = RC_UNSUP;
                rsp_now.reason_code = RS_UNKNOWN;
            end
        endcase
    end

    // sequencing: drop, answer at once, or wait for the store
    always_comb begin
        state_next = state_reg;
        rsp_next   = rsp_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take && !drop) begin
                    if (go_commit) begin
                        state_next = ST_COMMIT;
                    end else begin
                        state_next = ST_ANSWER;
                        rsp_next   = rsp_now;
                    end
                end
            end
            ST_COMMIT: begin
                if (nv_commit_done) begin
                    state_next           = ST_ANSWER;
                    rsp_next             = '0;
                    rsp_next.valid       = 1'b1;
                    rsp_next.pkt_type    = RSP_COMMIT;
                    rsp_next.chan_id     = commit_ch_reg;
                    rsp_next.resp_code   = nv_commit_fail ? RC_FAIL
                                                          : RC_DONE;
                    rsp_next.reason_code = RS_NONE;
                end
            end
            ST_ANSWER: begin
                if (rsp_ready) begin
                    state_next    = ST_IDLE;
                    rsp_next.valid = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // the store sees one request and one finalize pulse per commit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            rsp_reg       <= '0;
            ready_reg     <= 1'b0;
            req_reg       <= 1'b0;
            fin_reg       <= 1'b0;
            commit_ch_reg <= 8'h00;
        end else begin
            state_reg     <= state_next;
            rsp_reg       <= rsp_next;
            ready_reg     <= (state_next == ST_IDLE);
            req_reg       <= go_commit;
            fin_reg       <= go_commit;
            if (go_commit) begin
                commit_ch_reg <= cmd_in.chan_id;
            end
        end
    end

    assign cmd_ready     = ready_reg;
    assign rsp_out       = rsp_reg;
    assign nv_commit_req = req_reg;
    assign cfg_finalize  = fin_reg;

    // checks
    property p_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        take && drop |=> !rsp_reg.valid && ready_reg;
    endproperty
    a_drop: assert property (p_drop)
        else $error("errored command was answered");

    property p_commit_req;
        @(posedge clk_sys) disable iff (!rst_n)
        go_commit |=> req_reg && fin_reg ##1 !req_reg && !fin_reg;
    endproperty
    a_commit_req: assert property (p_commit_req)
        else $error("commit request pulse wrong");

    property p_commit_rsp;
        @(posedge clk_sys) disable iff (!rst_n)
        commit_end |=> rsp_reg.valid && rsp_reg.pkt_type == RSP_COMMIT &&
            rsp_reg.resp_code == ($past(nv_commit_fail) ? RC_FAIL : RC_DONE);
    endproperty
    a_commit_rsp: assert property (p_commit_rsp)
        else $error("commit answer missing");

    property p_commit_reason;
        @(posedge clk_sys) disable iff (!rst_n)
        rsp_reg.valid && rsp_reg.pkt_type == RSP_COMMIT
            |-> rsp_reg.reason_code <= RS_GEN_MAX;
    endproperty
    a_commit_reason: assert property (p_commit_reason)
        else $error("commit reason not generic");

    property p_asic_pkg;
        @(posedge clk_sys) disable iff (!rst_n)
        take && !drop && cmd_in.code == CMD_ASIC && is_pkg
            |=> rsp_reg.pkt_type == RSP_ASIC &&
                rsp_reg.word20 == $past(asic_pkg_word);
    endproperty
    a_asic_pkg: assert property (p_asic_pkg)
        else $error("package temperature answer wrong");

    property p_amb_chan;
        @(posedge clk_sys) disable iff (!rst_n)
        take && !drop && cmd_in.code == CMD_AMB && !is_pkg &&
            HAS_AMBIENT |=> rsp_reg.resp_code == RC_FAIL;
    endproperty
    a_amb_chan: assert property (p_amb_chan)
        else $error("channel ambient query accepted");

    property p_amb_count;
        @(posedge clk_sys) disable iff (!rst_n)
        take && !drop && cmd_in.code == CMD_AMB && is_pkg &&
            HAS_AMBIENT |=> rsp_reg.pkt_type == RSP_AMB &&
            rsp_reg.word20[7:0] == $past(amb_count);
    endproperty
    a_amb_count: assert property (p_amb_count)
        else $error("ambient count misplaced");

    property p_xcvr_na;
        @(posedge clk_sys) disable iff (!rst_n)
        take && !drop && cmd_in.code == CMD_XCVR && ch_ok &&
            HAS_XCVR && !xcvr_ready
            |=> rsp_reg.reason_code == RS_INFO_NA;
    endproperty
    a_xcvr_na: assert property (p_xcvr_na)
        else $error("missing transceiver not reported");

    property p_xcvr_data;
        @(posedge clk_sys) disable iff (!rst_n)
        take && !drop && cmd_in.code == CMD_XCVR && ch_ok &&
            HAS_XCVR && xcvr_ready
            |=> rsp_reg.pkt_type == RSP_XCVR &&
                rsp_reg.word24[31:16] == $past(xcvr_temp[idx]);
    endproperty
    a_xcvr_data: assert property (p_xcvr_data)
        else $error("transceiver temperature altered");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        rsp_reg.valid && !rsp_ready |=> rsp_reg.valid && $stable(rsp_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("answer changed before taken");
endmodule // sbtc_responder
`default_nettype wire

//--- sbtc_mc_model.sv
// sbtc_mc_model: management controller and settings store stand-in
// assumes one command outstanding; the bench calls xfer by hierarchy
`timescale 1ns/1ps
`default_nettype none
module sbtc_mc_model
    import sbtc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    output sbtc_cmd_type      cmd_in,
    input  wire logic         cmd_ready,
    input  wire sbtc_rsp_type rsp_out,
    output logic              rsp_ready,
    input  wire logic         nv_commit_req,
    input  wire logic         cfg_finalize,
    output logic              nv_commit_done,
    output logic              nv_commit_fail
);
    int req_seen   = 0;
    int fin_bad    = 0;
    int store_lat  = 3;
    bit store_fail = 1'b0;
    initial begin
        cmd_in = '0;
        rsp_ready = 1'b0;
        nv_commit_done = 1'b0;
        nv_commit_fail = 1'b1;
    end
    task automatic xfer(input logic [7:0] code, input logic [7:0] ch,
        input logic [1:0] err, input int stall,
        output sbtc_rsp_type r, output bit ok);
        sbtc_cmd_type c;
        int           n;
        r = '0;
        ok = 1'b0;
        c = '{1'b1, code, ch, err[1], err[0]};
        @(negedge clk_sys);
        cmd_in <= c;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) return;
        @(negedge clk_sys);
        // released request shows garbage, not the last command
        c = ~c;
        c.valid = 1'b0;
        cmd_in <= c;
        n = 0;
        while (rsp_out.valid !== 1'b1 && n < 30) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 30) begin
            ok = (err != 2'b00);
            return;
        end
        repeat (stall) @(negedge clk_sys);
        r = rsp_out;
        rsp_ready <= 1'b1;
        @(negedge clk_sys);
        rsp_ready <= 1'b0;
        ok = 1'b1;
    endtask
    always @(posedge clk_sys) begin
        if (rst_n && nv_commit_req !== cfg_finalize) fin_bad++;
        if (rst_n && nv_commit_req === 1'b1) req_seen++;
    end
    // slow store: done comes store_lat cycles after the request
    initial begin
        forever begin
            @(posedge clk_sys);
            if (rst_n === 1'b1 && nv_commit_req === 1'b1) begin
                repeat (store_lat) @(negedge clk_sys);
                nv_commit_done <= 1'b1;
                nv_commit_fail <= store_fail;
                @(negedge clk_sys);
                nv_commit_done <= 1'b0;
                nv_commit_fail <= ~store_fail;
            end
        end
    end
endmodule // sbtc_mc_model
`default_nettype wire

//--- testbench.sv
// testbench: scenario tasks for the settings-commit and temperature
// responder; assumes sbtc_mc_model as the far side and settings store
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("ERROR %s expected %0h seen %0h", n, e, g); \
        end \
    end
module testbench;
    import sbtc_pkg::*;
    logic                  clk_sys;
    logic                  rst_n;
    sbtc_cmd_type          cmd_in;
    logic                  cmd_ready;
    sbtc_rsp_type          rsp_out;
    logic                  rsp_ready;
    logic [1:0][15:0]      int_temp;
    logic [1:0][15:0]      int_thr;
    logic [3:0][15:0]      ext_temp;
    logic [3:0][15:0]      ext_thr;
    logic [7:0]            amb_count;
    logic [2:0][7:0]       amb_temp;
    logic [1:0]            pres_pin;
    logic [1:0]            pwr_pin;
    logic [1:0]            data_ok;
    logic [1:0][15:0]      x_temp;
    logic [1:0][15:0]      x_alarm;
    logic [1:0][15:0]      x_warn;
    logic                  nv_req;
    logic                  fin;
    logic                  nv_done;
    logic                  nv_fail;
    sbtc_rsp_type          rsp_min;
    wire [31:0]            min_codes = {rsp_min.resp_code,
                                        rsp_min.reason_code};
    int                    err_count = 0;
    int                    compares  = 0;
    sbtc_responder u_sbtc_responder (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_in(cmd_in), .cmd_ready(cmd_ready), .rsp_out(rsp_out),
        .rsp_ready(rsp_ready), .int_temp(int_temp), .int_thr(int_thr),
        .ext_temp(ext_temp), .ext_thr(ext_thr), .amb_count(amb_count),
        .amb_temp(amb_temp), .xcvr_present_pin(pres_pin),
        .xcvr_power_ok_pin(pwr_pin), .xcvr_data_ok(data_ok),
        .xcvr_temp(x_temp), .xcvr_alarm_thr(x_alarm),
        .xcvr_warn_thr(x_warn), .nv_commit_req(nv_req),
        .cfg_finalize(fin), .nv_commit_done(nv_done),
        .nv_commit_fail(nv_fail));
    sbtc_mc_model u_mc (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_in(cmd_in), .cmd_ready(cmd_ready), .rsp_out(rsp_out),
        .rsp_ready(rsp_ready), .nv_commit_req(nv_req),
        .cfg_finalize(fin), .nv_commit_done(nv_done),
        .nv_commit_fail(nv_fail));
    // same traffic into a build without ambient or transceiver support
    sbtc_responder #(.HAS_AMBIENT(1'b0), .HAS_XCVR(1'b0))
        u_sbtc_responder_min (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_in(cmd_in), .cmd_ready(), .rsp_out(rsp_min),
        .rsp_ready(rsp_ready), .int_temp(int_temp), .int_thr(int_thr),
        .ext_temp(ext_temp), .ext_thr(ext_thr), .amb_count(amb_count),
        .amb_temp(amb_temp), .xcvr_present_pin(pres_pin),
        .xcvr_power_ok_pin(pwr_pin), .xcvr_data_ok(data_ok),
        .xcvr_temp(x_temp), .xcvr_alarm_thr(x_alarm),
        .xcvr_warn_thr(x_warn), .nv_commit_req(), .cfg_finalize(),
        .nv_commit_done(nv_done), .nv_commit_fail(nv_fail));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run(input string nm, input logic [7:0] code,
        input logic [7:0] ch, input logic [15:0] rc, input logic [15:0] rs,
        input logic [31:0] w20, input logic [31:0] w24, input int stall);
        sbtc_rsp_type r;
        bit           ok;
        u_mc.xfer(code, ch, 2'b00, stall, r, ok);
        `CHK(nm, 1'b1, ok)
        if (!ok) give_verdict();
        `CHK(nm, code | RSP_FLAG, r.pkt_type)
        `CHK(nm, ch, r.chan_id)
        `CHK(nm, {rc, rs}, {r.resp_code, r.reason_code})
        `CHK(nm, 1'b1, r.reason_code <= RS_GEN_MAX)
        if (rc == RC_DONE && code != CMD_COMMIT) begin
            `CHK(nm, w20, r.word20)
        end
        if (rc == RC_DONE && code == CMD_XCVR) begin
            `CHK(nm, w24, r.word24)
        end
    endtask
    task automatic t_asic();
        // internal slot 0 is hotter but slot 1 is nearer its limit
        int_temp = {16'h0032, 16'h0050};
        int_thr  = {16'h003C, 16'h0064};
        ext_temp = {16'h0014, 16'hFFFB, 16'h0030, 16'h0070};
        ext_thr  = {16'h005A, 16'h0000, 16'h0020, 16'h0010};
        run("asic_pkg", CMD_ASIC, CH_PKG, RC_DONE, RS_NONE,
            32'h003C_0032, 0, 0);
        run("asic_ch1", CMD_ASIC, 8'h01, RC_DONE, RS_NONE,
            32'h0000_FFFB, 0, 3);
        run("asic_ch5", CMD_ASIC, 8'h05, RC_FAIL, RS_BAD_PARAM,
            0, 0, 0);
    endtask
    task automatic t_amb();
        amb_count = 8'h02;
        amb_temp = {8'h4D, 8'h19, 8'hFD};
        run("amb_pkg", CMD_AMB, CH_PKG, RC_DONE, RS_NONE,
            32'h0019_FD02, 0, 1);
        `CHK("amb_min", {RC_UNSUP, RS_UNKNOWN}, min_codes)
        run("amb_ch0", CMD_AMB, 8'h00, RC_FAIL, RS_BAD_PARAM,
            0, 0, 0);
    endtask
    task automatic t_xcvr();
        run("xcvr_ch0", CMD_XCVR, 8'h00, RC_DONE, RS_NONE,
            32'h5500_4B00, 32'h1A2B_0000, 0);
        `CHK("xcvr_min", {RC_UNSUP, RS_UNKNOWN}, min_codes)
        run("xcvr_ch1", CMD_XCVR, 8'h01, RC_DONE, RS_NONE,
            32'h5000_4600, 32'h8C80_0000, 2);
        run("xcvr_pkg", CMD_XCVR, CH_PKG, RC_FAIL, RS_BAD_PARAM,
            0, 0, 0);
        data_ok[1] = 1'b0;
        run("xcvr_nodata", CMD_XCVR, 8'h01, RC_FAIL, RS_INFO_NA,
            0, 0, 0);
        pres_pin[0] = 1'b0;
        pwr_pin[1] = 1'b0;
        data_ok[1] = 1'b1;
        // pins pass a synchroniser before they are seen
        repeat (8) @(negedge clk_sys);
        run("xcvr_absent", CMD_XCVR, 8'h00, RC_FAIL, RS_INFO_NA,
            0, 0, 0);
        run("xcvr_nopwr", CMD_XCVR, 8'h01, RC_FAIL, RS_INFO_NA,
            0, 0, 0);
    endtask
    task automatic t_reset();
        // a reset in mid-run clears the answer and the handshake
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK("reset_out", 0, {cmd_ready, rsp_out})
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK("reset_rel", 1'b1, cmd_ready)
    endtask
    task automatic t_commit();
        int base;
        base = u_mc.req_seen;
        run("commit", CMD_COMMIT, CH_PKG, RC_DONE, RS_NONE,
            0, 0, 2);
        `CHK("commit_req", base + 1, u_mc.req_seen)
        u_mc.store_fail = 1'b1;
        run("commit_fail", CMD_COMMIT, CH_PKG, RC_FAIL, RS_NONE,
            0, 0, 0);
        u_mc.store_fail = 1'b0;
        run("commit_ch", CMD_COMMIT, 8'h00, RC_FAIL, RS_BAD_PARAM,
            0, 0, 0);
        `CHK("commit_req", base + 2, u_mc.req_seen)
        `CHK("finalize", 0, u_mc.fin_bad)
    endtask
    task automatic t_drop();
        sbtc_rsp_type r;
        bit           ok;
        u_mc.xfer(CMD_ASIC, CH_PKG, 2'b10, 0, r, ok);
        `CHK("drop_csum", 2'b01, {r.valid, ok})
        u_mc.xfer(CMD_COMMIT, CH_PKG, 2'b01, 0, r, ok);
        `CHK("drop_id", 2'b01, {r.valid, ok})
        `CHK("drop_store", 2, u_mc.req_seen)
        run("unknown", 8'h50, CH_PKG, RC_UNSUP, RS_UNKNOWN,
            0, 0, 0);
    endtask
    initial begin
        rst_n = 1'b0;
        {int_temp, int_thr, ext_temp, ext_thr} = '0;
        {amb_count, amb_temp} = '0;
        pres_pin = 2'b11;
        pwr_pin = 2'b11;
        data_ok = 2'b11;
        x_temp = {16'h8C80, 16'h1A2B};
        x_alarm = {16'h5000, 16'h5500};
        x_warn = {16'h4600, 16'h4B00};
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        t_asic();
        t_amb();
        t_reset();
        t_commit();
        t_drop();
        t_xcvr();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
